/* File: scfg_top.sv */
// System clock and reset configuration: vector overlay, reset cause flags,
// main clock selection with update handshake, clock dividers and gates.
// Assumes source clocks and reset sources are levels synchronous to clock,
// sampled well above their own rate; sys_rst is the power-on reset.
//
// How it works
// - Vector select 0 boot ROM, 1 SRAM, 2 flash; 3 is reserved.
// - ROM or RAM overlays only the lowest 512 bytes from address zero.
// - Vector select resets to 2, flash at address zero.
// - Cause bit 0 flags power-on or brownout reset, else reads 0.
// - Cause bit 1 flags a reset through the external reset pin.
// - Cause bit 2 flags a watchdog reset; bit 3 is reserved.
// - Cause bit 4 flags a software system reset; bits 31:5 reserved.
// - Writing one clears a cause bit; writing zero leaves it.
// - Power-on reset clears all cause bits except the power-on flag.
// - A source still active after power-on release sets its bit too.
// - Main source 0 fast, 1 external, 2 low-power, 3 halved fast; resets 0.
// - New main source applies only on update bit rising 0 to 1.
// - System ratio 0 stops clock, N divides by N; resets to 1.
// - ADC source 0 fast, 1 external, 2 and 3 none; resets 0.
// - ADC ratio 0 disables clock, N divides by N; resets to 0.
// - Gate bit 0 passes low-power clock to watchdog; resets 1.
// - Gate bit 1 passes low-power clock to wake-up timer; resets 0.
//
// Chosen here: the APB interface to the registers.
module scfg_top
    import scfg_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic sys_rst,
    // Register bus.
    input wire scfg_apb_req_type apb_req,
    output scfg_apb_rsp_type apb_rsp,
    // Source clocks and reset sources.
    input wire scfg_src_type src_clks,
    input wire scfg_rst_src_type rst_srcs,
    // Memory fetch address and overlay answer.
    input wire logic [31:0] mem_addr,
    output logic overlay_hit,
    output scfg_vec_type overlay_mem,
    // Generated clocks.
    output scfg_clk_out_type clk_out
);

    // Picks the main clock source level.
    function automatic logic main_pick(scfg_msrc_type sel, scfg_src_type s);
        logic v;
        v = 1'b0;
        case (sel)
            MSRC_FAST: v = s.internal_fast_osc;
            MSRC_EXT: v = s.ext_clk;
            MSRC_LP: v = s.lp_osc;
            MSRC_HALF: v = s.halved_fast_osc;
            default: v = 1'b0;
        endcase
        return v;
    endfunction : main_pick

    // Picks the ADC clock source level; the none codes give a quiet low.
    function automatic logic adc_pick(scfg_asrc_type sel, scfg_src_type s);
        logic v;
        v = 1'b0;
        case (sel)
            ASRC_FAST: v = s.internal_fast_osc;
            ASRC_EXT: v = s.ext_clk;
            default: v = 1'b0;
        endcase
        return v;
    endfunction : adc_pick

    // Advances a divider on a source rising edge. A new ratio is only taken
    // at the end of a whole output period, or at the next source rising edge while stopped.
    function automatic scfg_div_type div_step(scfg_div_type cur,
                                              logic [7:0] req,
                                              logic rise);
        scfg_div_type nx;
        nx = cur;
        if (rise) begin
            if (cur.ratio == 8'h00 || cur.cnt == cur.ratio - 8'h01) begin
                nx.cnt = 8'h00;
                nx.ratio = req;
            end else begin
                nx.cnt = cur.cnt + 8'h01;
            end
        end
        return nx;
    endfunction : div_step

    // Divider output level: low when stopped, the source itself for one,
    // else high for the first half of the count.
    function automatic logic div_out(scfg_div_type d, logic lvl);
        logic [7:0] half;
        logic v;
        half = (d.ratio >> 1) + {7'h00, d.ratio[0]};
        if (d.ratio == 8'h00) begin
            v = 1'b0;
        end else if (d.ratio == 8'h01) begin
            v = lvl;
        end else begin
            v = (d.cnt < half);
        end
        return v;
    endfunction : div_out

    // Bus decode.
    logic acc;
    logic wr;
    logic setup;
    assign acc = apb_req.psel & apb_req.penable;
    assign wr = acc & apb_req.pwrite;
    assign setup = apb_req.psel & ~apb_req.penable;

    logic wr_vec;
    logic wr_cause;
    logic wr_msrc;
    logic wr_upd;
    logic wr_sratio;
    logic wr_asrc;
    logic wr_aratio;
    logic wr_gates;
    assign wr_vec = wr && apb_req.paddr == ADDR_VECTOR;
    assign wr_cause = wr && apb_req.paddr == ADDR_CAUSE;
    assign wr_msrc = wr && apb_req.paddr == ADDR_MAIN_SRC;
    assign wr_upd = wr && apb_req.paddr == ADDR_MAIN_UPD;
    assign wr_sratio = wr && apb_req.paddr == ADDR_SYS_RATIO;
    assign wr_asrc = wr && apb_req.paddr == ADDR_ADC_SRC;
    assign wr_aratio = wr && apb_req.paddr == ADDR_ADC_RATIO;
    assign wr_gates = wr && apb_req.paddr == ADDR_LP_GATES;

    // Software visible state.
    scfg_vec_type vec_q;
    logic [4:0] cause_q;
    scfg_msrc_type msrc_q;
    logic upd_q;
    logic [7:0] sratio_q;
    scfg_asrc_type asrc_q;
    logic [7:0] aratio_q;
    logic [1:0] gates_q;

    // Vector location; the reserved code is ignored on write.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            vec_q <= VEC_FLASH;
        end else if (wr_vec && apb_req.pwdata[1:0] != VEC_RSVD) begin
            vec_q <= scfg_vec_type'(apb_req.pwdata[1:0]);
        end
    end

    // Overlay decode of the fetch address, one cycle behind it.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            overlay_hit <= 1'b0;
            overlay_mem <= VEC_FLASH;
        end else begin
            overlay_hit <= (mem_addr < OVERLAY_BYTES) && (vec_q != VEC_FLASH);
            overlay_mem <= vec_q;
        end
    end

    // Reset cause flags; a live source beats a clear in the same cycle.
    logic [4:0] cause_set;
    logic [4:0] cause_clr;
    always_comb begin
        cause_set = 5'h00;
        cause_set[CAUSE_POR] = rst_srcs.brownout_detect;
        cause_set[CAUSE_EXT] = ~rst_srcs.ext_pin_reset_n;
        cause_set[CAUSE_WDG] = rst_srcs.watchdog_reset;
        cause_set[CAUSE_SW] = rst_srcs.software_reset;
        cause_clr = wr_cause ? apb_req.pwdata[4:0] : 5'h00;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cause_q <= CAUSE_RESET;
        end else begin
            // A source still held after release sets its flag here.
            cause_q <= ((cause_q & ~cause_clr) | cause_set) & CAUSE_MASK;
        end
    end

    // Main clock source select and update bit.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            msrc_q <= MSRC_FAST;
        end else if (wr_msrc) begin
            msrc_q <= scfg_msrc_type'(apb_req.pwdata[1:0]);
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            upd_q <= 1'b0;
        end else if (wr_upd) begin
            upd_q <= apb_req.pwdata[UPD_BIT];
        end
    end

    // Update request: only a zero to one step of the update bit latches
    // the selected source.
    logic upd_rise;
    logic pend_q;
    scfg_msrc_type tgt_q;
    scfg_msrc_type mact_q;
    logic main_lvl;
    logic tgt_lvl;
    logic main_swap;
    assign upd_rise = wr_upd & apb_req.pwdata[UPD_BIT] & ~upd_q;
    assign main_lvl = main_pick(mact_q, src_clks);
    assign tgt_lvl = main_pick(tgt_q, src_clks);
    assign main_swap = pend_q & ~main_lvl & ~tgt_lvl;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tgt_q <= MSRC_FAST;
        end else if (upd_rise) begin
            tgt_q <= msrc_q;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pend_q <= 1'b0;
        end else if (upd_rise) begin
            pend_q <= 1'b1;
        end else if (main_swap) begin
            pend_q <= 1'b0;
        end
    end

    // The switch happens only while old and new sources are both low.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mact_q <= MSRC_FAST;
        end else if (main_swap && !upd_rise) begin
            mact_q <= tgt_q;
        end
    end

    logic main_q;
    logic main_rise;
    assign main_rise = main_lvl & ~main_q;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            main_q <= 1'b0;
        end else begin
            main_q <= main_lvl;
        end
    end

    // System clock ratio and divider.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sratio_q <= SYS_RATIO_RESET;
        end else if (wr_sratio) begin
            sratio_q <= apb_req.pwdata[7:0];
        end
    end

    scfg_div_type sdiv_q;
    scfg_div_type sdiv_d;
    logic sys_q;
    assign sdiv_d = div_step(sdiv_q, sratio_q, main_rise);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sdiv_q <= '{cnt: 8'h00, ratio: SYS_RATIO_RESET};
            sys_q <= 1'b0;
        end else begin
            sdiv_q <= sdiv_d;
            sys_q <= div_out(sdiv_d, main_lvl);
        end
    end

    // ADC clock source, switched only while both levels are low.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            asrc_q <= ASRC_FAST;
        end else if (wr_asrc) begin
            asrc_q <= scfg_asrc_type'(apb_req.pwdata[1:0]);
        end
    end

    scfg_asrc_type aact_q;
    logic adc_lvl;
    logic adc_new_lvl;
    assign adc_lvl = adc_pick(aact_q, src_clks);
    assign adc_new_lvl = adc_pick(asrc_q, src_clks);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            aact_q <= ASRC_FAST;
        end else if (!adc_lvl && !adc_new_lvl) begin
            aact_q <= asrc_q;
        end
    end

    logic adc_prev_q;
    logic adc_rise;
    assign adc_rise = adc_lvl & ~adc_prev_q;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            adc_prev_q <= 1'b0;
        end else begin
            adc_prev_q <= adc_lvl;
        end
    end

    // ADC ratio and divider.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            aratio_q <= ADC_RATIO_RESET;
        end else if (wr_aratio) begin
            aratio_q <= apb_req.pwdata[7:0];
        end
    end

    scfg_div_type adiv_q;
    scfg_div_type adiv_d;
    logic adc_q;
    assign adiv_d = div_step(adiv_q, aratio_q, adc_rise);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            adiv_q <= '{cnt: 8'h00, ratio: ADC_RATIO_RESET};
            adc_q <= 1'b0;
        end else begin
            adiv_q <= adiv_d;
            adc_q <= div_out(adiv_d, adc_lvl);
        end
    end

    // Low-power oscillator gates; a new gate setting waits for a low phase.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            gates_q <= GATES_RESET;
        end else if (wr_gates) begin
            gates_q <= apb_req.pwdata[1:0];
        end
    end

    logic [1:0] gact_q;
    logic wdg_q;
    logic wake_q;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            gact_q <= GATES_RESET;
        end else if (!src_clks.lp_osc) begin
            gact_q <= gates_q;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wdg_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            wdg_q <= src_clks.lp_osc & gact_q[GATE_WDG];
            wake_q <= src_clks.lp_osc & gact_q[GATE_WAKE];
        end
    end

    assign clk_out = '{main_clk: main_q,
                       sys_clk: sys_q,
                       adc_clk: adc_q,
                       watchdog_clk: wdg_q,
                       wake_up_timer_clk: wake_q};

    // Read data is prepared in the setup cycle and held for the access.
    logic [31:0] rd_d;
    logic err_d;
    always_comb begin
        rd_d = 32'h0000_0000;
        err_d = 1'b0;
        case (apb_req.paddr)
            ADDR_VECTOR: rd_d[1:0] = vec_q;
            ADDR_CAUSE: rd_d[4:0] = cause_q;
            ADDR_MAIN_SRC: rd_d[1:0] = msrc_q;
            ADDR_MAIN_UPD: rd_d[UPD_BIT] = upd_q;
            ADDR_SYS_RATIO: rd_d[7:0] = sratio_q;
            ADDR_ADC_SRC: rd_d[1:0] = asrc_q;
            ADDR_ADC_RATIO: rd_d[7:0] = aratio_q;
            ADDR_LP_GATES: rd_d[1:0] = gates_q;
            default: err_d = 1'b1;
        endcase
    end

    logic [31:0] prdata_q;
    logic err_q;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            prdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= rd_d;
            err_q <= err_d;
        end
    end

    assign apb_rsp = '{prdata: prdata_q,
                       pready: acc,
                       pslverr: acc & err_q};

endmodule : scfg_top

/* File: scfg_pkg.sv */
// Constants, types and register map of the system clock and reset config block.
// Assumes a 32-bit APB master and source clocks that arrive as levels sampled on clock.
package scfg_pkg;

    // Register byte addresses.
    localparam logic [31:0] ADDR_VECTOR = 32'h4004_8000;
    localparam logic [31:0] ADDR_CAUSE = 32'h4004_8038;
    localparam logic [31:0] ADDR_MAIN_SRC = 32'h4004_8050;
    localparam logic [31:0] ADDR_MAIN_UPD = 32'h4004_8054;
    localparam logic [31:0] ADDR_SYS_RATIO = 32'h4004_8058;
    localparam logic [31:0] ADDR_ADC_SRC = 32'h4004_8064;
    localparam logic [31:0] ADDR_ADC_RATIO = 32'h4004_8068;
    localparam logic [31:0] ADDR_LP_GATES = 32'h4004_807C;

    // Field positions.
    localparam int CAUSE_POR = 0;
    localparam int CAUSE_EXT = 1;
    localparam int CAUSE_WDG = 2;
    localparam int CAUSE_SW = 4;
    localparam int UPD_BIT = 0;
    localparam int GATE_WDG = 0;
    localparam int GATE_WAKE = 1;

    // Reset values and masks.
    localparam logic [4:0] CAUSE_RESET = 5'h01;
    localparam logic [4:0] CAUSE_MASK = 5'h17;
    localparam logic [7:0] SYS_RATIO_RESET = 8'h01;
    localparam logic [7:0] ADC_RATIO_RESET = 8'h00;
    localparam logic [1:0] GATES_RESET = 2'h1;

    // Size of the vector overlay at address zero.
    localparam logic [31:0] OVERLAY_BYTES = 32'h0000_0200;

    typedef enum logic [1:0] {
        VEC_BOOT_ROM = 2'b00,
        VEC_SRAM = 2'b01,
        VEC_FLASH = 2'b10,
        VEC_RSVD = 2'b11
    } scfg_vec_type;

    typedef enum logic [1:0] {
        MSRC_FAST = 2'b00,
        MSRC_EXT = 2'b01,
        MSRC_LP = 2'b10,
        MSRC_HALF = 2'b11
    } scfg_msrc_type;

    typedef enum logic [1:0] {
        ASRC_FAST = 2'b00,
        ASRC_EXT = 2'b01,
        ASRC_NONE2 = 2'b10,
        ASRC_NONE3 = 2'b11
    } scfg_asrc_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } scfg_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } scfg_apb_rsp_type;

    typedef struct packed {
        logic internal_fast_osc;
        logic ext_clk;
        logic lp_osc;
        logic halved_fast_osc;
    } scfg_src_type;

    typedef struct packed {
        logic brownout_detect;
        logic ext_pin_reset_n;
        logic watchdog_reset;
        logic software_reset;
    } scfg_rst_src_type;

    typedef struct packed {
        logic main_clk;
        logic sys_clk;
        logic adc_clk;
        logic watchdog_clk;
        logic wake_up_timer_clk;
    } scfg_clk_out_type;

    typedef struct packed {
        logic [7:0] cnt;
        logic [7:0] ratio;
    } scfg_div_type;

endpackage : scfg_pkg

/* File: scfg_monitor.sv */
// Checker for the system clock and reset configuration block.
// Assumes it is bound to scfg_top and that source clocks stay high and low for at least 2 cycles.
module scfg_monitor
    import scfg_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic sys_rst,
    // Register bus.
    input wire scfg_apb_req_type apb_req,
    input wire scfg_apb_rsp_type apb_rsp,
    // Sources.
    input wire scfg_src_type src_clks,
    input wire scfg_rst_src_type rst_srcs,
    // Overlay and clocks.
    input wire logic [31:0] mem_addr,
    input wire logic overlay_hit,
    input wire scfg_vec_type overlay_mem,
    input wire scfg_clk_out_type clk_out
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    logic rd_cause;
    assign rd_cause = apb_req.psel && apb_req.penable && !apb_req.pwrite
        && apb_req.paddr == ADDR_CAUSE;

    a_vector_legal: assert property (overlay_mem != VEC_RSVD)
        else $error("reserved vector code in use");
    a_overlay_window: assert property (overlay_hit == ($past(mem_addr) < OVERLAY_BYTES
        && overlay_mem inside {VEC_BOOT_ROM, VEC_SRAM})) else $error("overlay decode wrong");
    a_flash_after_reset: assert property ($fell(sys_rst) |-> overlay_mem == VEC_FLASH)
        else $error("vector select not flash after reset");
    a_por_flag_set: assert property ($past(rst_srcs.brownout_detect, 2)
        && $past(rst_srcs.brownout_detect) && rd_cause |-> apb_rsp.prdata[CAUSE_POR])
        else $error("brownout flag not set");
    a_cause_reserved_zero: assert property (rd_cause
        |-> apb_rsp.prdata[31:5] == '0 && !apb_rsp.prdata[3]) else $error("reserved cause bits set");
    a_wdg_gate_source: assert property (clk_out.watchdog_clk |-> $past(src_clks.lp_osc))
        else $error("watchdog clock high without source");
    a_wake_gate_source: assert property (clk_out.wake_up_timer_clk |-> $past(src_clks.lp_osc))
        else $error("wake clock high without source");
    a_main_no_glitch: assert property ($changed(clk_out.main_clk) |=> $stable(clk_out.main_clk))
        else $error("short main clock pulse");
    a_sys_no_glitch: assert property ($changed(clk_out.sys_clk) |=> $stable(clk_out.sys_clk))
        else $error("short system clock pulse");
    a_adc_no_glitch: assert property ($changed(clk_out.adc_clk) |=> $stable(clk_out.adc_clk))
        else $error("short adc clock pulse");

    c_cause_read: cover property (rd_cause);
    c_overlay_hit: cover property (overlay_hit);
    c_adc_running: cover property ($rose(clk_out.adc_clk));
endmodule : scfg_monitor

bind scfg_top scfg_monitor mon (.clock(clock), .sys_rst(sys_rst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .src_clks(src_clks), .rst_srcs(rst_srcs), .mem_addr(mem_addr),
    .overlay_hit(overlay_hit), .overlay_mem(overlay_mem), .clk_out(clk_out));

/* File: system_clock_reset_config_tb.sv */
// Self-checking testbench for the system clock and reset configuration block.
// Assumes scfg_top answers APB with zero wait states and sources far slower than clock.
module system_clock_reset_config_tb import scfg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

`define CHECK(got, exp, msg) \
    begin \
        checks++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("mismatch at %0t: %s", $time, msg); \
        end \
    end

    logic clock;
    logic sys_rst;
    scfg_apb_req_type apb_req;
    scfg_apb_rsp_type apb_rsp;
    scfg_src_type src_clks = '0;
    scfg_rst_src_type rst_srcs;
    logic [31:0] mem_addr;
    logic overlay_hit;
    scfg_vec_type overlay_mem;
    scfg_clk_out_type clk_out;
    logic [7:0] phase_q = 8'h00;
    logic [31:0] rd;
    logic err;
    int num_errors = 0;
    int checks = 0;

    scfg_top uut (.clock(clock), .sys_rst(sys_rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .src_clks(src_clks), .rst_srcs(rst_srcs), .mem_addr(mem_addr),
        .overlay_hit(overlay_hit), .overlay_mem(overlay_mem), .clk_out(clk_out));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Sources: fast period 8, external 12, low-power 20, halved fast 16 cycles.
    always @(posedge clock) begin
        phase_q <= (phase_q == 8'd239) ? 8'h00 : phase_q + 8'h01;
        src_clks <= '{phase_q % 8 < 4, phase_q % 12 < 6, phase_q % 20 < 10, phase_q % 16 < 8};
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clock);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        if (apb_rsp.pready !== 1'b1) begin
            num_errors++;
            $display("mismatch at %0t: no ready", $time);
            summarize();
        end
        apb_req <= '0;
        @(posedge clock);
    endtask : apb

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rchk(input logic [31:0] a, input logic [31:0] exp, input string msg);
        apb(1'b0, a, '0);
        `CHECK({err, rd}, {1'b0, exp}, msg)
    endtask : rchk

    // Measures the cycles between two rising edges of a clock output, 0 if it stays still.
    task automatic meas(input int b, input int exp, input string msg);
        logic prev;
        int t0;
        int rises;
        int p;
        for (int k = 0; k < 2; k++) begin
            rises = 0;
            t0 = 0;
            p = 0;
            prev = clk_out[b];
            for (int n = 0; n < 4200 && rises < 2; n++) begin
                @(posedge clock);
                #1;
                if (clk_out[b] === 1'b1 && prev === 1'b0) begin
                    rises++;
                    p = n - t0;
                    t0 = n;
                end
                prev = clk_out[b];
            end
        end
        @(posedge clock);
        `CHECK(rises < 2 ? 0 : p, exp, msg)
    endtask : meas

    task automatic reset_values();
        rchk(ADDR_VECTOR, 32'h0000_0002, "vector reset");
        rchk(ADDR_CAUSE, 32'h0000_0001, "cause reset");
        rchk(ADDR_MAIN_SRC, 32'h0000_0000, "main source reset");
        rchk(ADDR_MAIN_UPD, 32'h0000_0000, "update reset");
        rchk(ADDR_SYS_RATIO, 32'h0000_0001, "system ratio reset");
        rchk(ADDR_ADC_SRC, 32'h0000_0000, "adc source reset");
        rchk(ADDR_ADC_RATIO, 32'h0000_0000, "adc ratio reset");
        rchk(ADDR_LP_GATES, 32'h0000_0001, "gates reset");
        apb(1'b0, 32'h4004_8004, 32'h0000_0000);
        `CHECK({err, rd}, {1'b1, 32'h0000_0000}, "unmapped read")
        $display("test reset_values done");
    endtask : reset_values

    task automatic vector_overlay();
        logic [1:0] exp;
        for (int v = 0; v < 4; v++) begin
            wr(ADDR_VECTOR, 32'(v));
            exp = (v == 3) ? 2'h2 : 2'(v);
            mem_addr <= 32'h0000_01FC;
            repeat (2) @(posedge clock);
            #1;
            `CHECK({overlay_hit, overlay_mem}, {exp < 2, exp}, "low fetch")
            @(posedge clock);
            mem_addr <= 32'h0000_0200;
            repeat (2) @(posedge clock);
            #1;
            `CHECK(overlay_hit, 1'b0, "fetch past overlay")
            @(posedge clock);
            rchk(ADDR_VECTOR, {30'h0, exp}, "vector readback");
        end
        $display("test vector_overlay done");
    endtask : vector_overlay

    task automatic clock_switch();
        int per[4] = '{8, 12, 20, 16};
        wr(ADDR_MAIN_SRC, 32'h0000_0001);
        meas(4, 8, "source without update");
        for (int s = 1; s < 5; s++) begin
            wr(ADDR_MAIN_SRC, 32'(s % 4));
            wr(ADDR_MAIN_UPD, 32'h0000_0000);
            wr(ADDR_MAIN_UPD, 32'h0000_0001);
            meas(4, per[s % 4], "main source");
        end
        wr(ADDR_MAIN_SRC, 32'h0000_0001);
        wr(ADDR_MAIN_UPD, 32'h0000_0001);
        meas(4, 8, "update already one");
        $display("test clock_switch done");
    endtask : clock_switch

    task automatic dividers();
        int ratio[5] = '{2, 3, 255, 0, 1};
        int aper[4] = '{16, 24, 0, 0};
        foreach (ratio[i]) begin
            wr(ADDR_SYS_RATIO, 32'(ratio[i]));
            meas(3, 8 * ratio[i], "system ratio");
        end
        meas(2, 0, "adc off after reset");
        wr(ADDR_ADC_RATIO, 32'h0000_0002);
        foreach (aper[s]) begin
            wr(ADDR_ADC_SRC, 32'(s));
            meas(2, aper[s], "adc source");
        end
        $display("test dividers done");
    endtask : dividers

    task automatic gates();
        meas(1, 20, "watchdog clock on");
        meas(0, 0, "wake clock off");
        wr(ADDR_LP_GATES, 32'h0000_0002);
        meas(1, 0, "watchdog clock off");
        meas(0, 20, "wake clock on");
        $display("test gates done");
    endtask : gates

    task automatic cause_flags();
        rst_srcs <= 4'b0011;
        repeat (2) @(posedge clock);
        rst_srcs <= 4'b0100;
        @(posedge clock);
        rchk(ADDR_CAUSE, 32'h0000_0017, "all flags");
        wr(ADDR_CAUSE, 32'h0000_0002);
        rchk(ADDR_CAUSE, 32'h0000_0015, "clear pin flag");
        wr(ADDR_CAUSE, 32'h0000_0000);
        rchk(ADDR_CAUSE, 32'h0000_0015, "zero write");
        wr(ADDR_CAUSE, 32'h0000_0015);
        rchk(ADDR_CAUSE, 32'h0000_0000, "all cleared");
        rst_srcs <= 4'b1100;
        @(posedge clock);
        rchk(ADDR_CAUSE, 32'h0000_0001, "brownout flag");
        rst_srcs <= 4'b0011;
        @(posedge clock);
        rst_srcs <= 4'b0000;
        sys_rst <= 1'b1;
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clock);
        rst_srcs <= 4'b0100;
        @(posedge clock);
        rchk(ADDR_CAUSE, 32'h0000_0003, "power-on with pin held");
        $display("test cause_flags done");
    endtask : cause_flags

    initial begin
        sys_rst = 1'b1;
        apb_req = '0;
        rst_srcs = 4'b0100;
        mem_addr = 32'h0000_0000;
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        reset_values();
        vector_overlay();
        clock_switch();
        dividers();
        gates();
        cause_flags();
        summarize();
    end
endmodule : system_clock_reset_config_tb
